// ### src/adc_ctrl_consts.svh
// Constants of the conversion and serial readout control block
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
`define CLK_MHZ 200
`define WAKE_TIME_US 1000
`define RST_WAIT_US 500
`define OUT_RATE_PERIOD_US 60000
`define CONV_PERIODS 2
`define RESULT_BITS 24
`define ONES_RESET_COUNT 32
`define CMD_LAST_BIT 5'h07
`define CMD_WEN_BIT 7
`define CMD_RD_BIT 6
`define CMD_RS_MSB 5
`define CMD_RS_LSB 3
`define CMD_CREAD_BIT 2
`define CMD_CREAD_ON 8'h5c
`define CMD_CREAD_OFF 8'h58
`define RS_STATUS 3'h0
`define RS_MODE 3'h1
`define RS_CONF 3'h2
`define RS_DATA 3'h3
`define LEN_BYTE 5'h08
`define LEN_HALF 5'h10
`define MD_MSB 15
`define MD_LSB 13
`define MD_CONT 3'h0
`define MD_SINGLE 3'h1
`define CONF_BO_BIT 13
`define CONF_UNI_BIT 12
`define MODE_RST 16'h0000
`define CONF_RST 16'h0000
`define BUF_DEPTH 2'h2
`endif

// ### src/adc_ctrl_pkg.sv
// Types of the conversion and serial readout control block
`include "adc_ctrl_consts.svh"
package adc_ctrl_pkg;
    typedef enum logic [1:0] {
        CV_RUN = 2'b00,
        CV_WAKE = 2'b01,
        CV_OFF = 2'b10
    } conv_state_t;

    typedef enum logic [1:0] {
        PH_CMD = 2'b00,
        PH_WR = 2'b01,
        PH_RD = 2'b10
    } ser_phase_t;

    typedef struct packed {
        logic [2:0] sclk_s;
        logic [1:0] cs_s;
        logic [1:0] din_s;
        ser_phase_t ph;
        logic [4:0] in_cnt;
        logic [`RESULT_BITS-1:0] in_sh;
        logic [2:0] rs;
        logic [4:0] len;
        logic [4:0] out_cnt;
        logic [`RESULT_BITS-1:0] out_sh;
        logic cread;
        logic rdy_n;
        logic dout;
        logic oe_n;
        logic [5:0] ones;
        logic [31:0] wait_cnt;
        logic [15:0] mode;
        logic [15:0] conf;
        logic [`RESULT_BITS-1:0] data;
        conv_state_t cv;
        logic [31:0] tmr;
        logic [1:0][`RESULT_BITS-1:0] fifo;
        logic wp;
        logic rp;
        logic [1:0] cnt;
        logic flt_rst;
    } ctrl_state_t;
endpackage : adc_ctrl_pkg

// ### src/adc_conversion_readout_control.sv
// Conversion sequencing and serial result readout of a sigma-delta converter
//
// Notes on behaviour
// - Single-conversion mode code powers up, converts once, then shuts down.
// - Entering single mode waits the oscillator power-up time; continuous mode converts at once.
// - A single conversion takes two output-rate periods.
// - Single mode: pin low when ready, high after read until next result.
// - Outside continuous read the held result may be read again and again.
// - After reset the converter runs continuous conversions unprompted.
// - Continuous mode: each result clears ready flag; pin low while selected.
// - Host commands a data read; result shifts out, then line returns high.
// - Command byte 0x5c enters continuous read; no per-result command then.
// - Continuous read puts each completed word on the data-out line.
// - Continuous read: each word read once; line high until next word.
// - Unfinished word is dropped and the new result loaded in its place.
// - Command 0x58 while line low leaves continuous read; DIN is watched.
// - 32 consecutive ones on DIN reset interface, filter and registers.
// - Same reset at power-up; host then waits 500 us before access.
// - Unipolar coding is straight binary.
// - Bipolar coding is offset binary.
// - Configuration polarity bit selects unipolar or bipolar coding.
// - One configuration bit switches both burnout currents together.
// - Every transaction starts with a communication register write; in continuous read the code shifts words out with none.
// - After serial reset the port expects a communication register write.
// - Finishing a data register read sets the ready flag and pin high.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_consts.svh"
module adc_conversion_readout_control #(
    parameter int unsigned RES_W = `RESULT_BITS,
    parameter int unsigned WAKE_CYC = `WAKE_TIME_US * `CLK_MHZ,
    parameter int unsigned RST_WAIT_CYC = `RST_WAIT_US * `CLK_MHZ,
    parameter int unsigned RATE_CYC = `OUT_RATE_PERIOD_US * `CLK_MHZ
) (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic din_in,
    input wire logic [`RESULT_BITS-1:0] sample_in,
    output logic dout_out,
    output logic dout_oe_n_out,
    output logic burnout_en_out,
    output logic conv_active_out,
    output logic filter_rst_out,
    output logic serial_busy_out
);
    adc_ctrl_pkg::ctrl_state_t st_q;
    adc_ctrl_pkg::ctrl_state_t st_d;
    logic rise_ev;
    logic fall_ev;
    logic shifting;
    logic conv_end;
    logic push;
    logic pop;
    logic cmd_done;
    logic rd_done;
    logic ones_rst;
    logic single;
    logic [7:0] cmd;
    logic [`RESULT_BITS-1:0] wd;
    logic [31:0] lim;

    // ---------------------------------------------------------------
    // Decoders
    // ---------------------------------------------------------------
    function automatic logic [4:0] reg_len(input logic [2:0] rs);
        if (rs == `RS_STATUS) begin
            return `LEN_BYTE;
        end else if (rs == `RS_MODE || rs == `RS_CONF) begin
            return `LEN_HALF;
        end else if (rs == `RS_DATA) begin
            return 5'(RES_W);
        end else begin
            return `LEN_BYTE;
        end
    endfunction : reg_len

    // Values left-aligned so the shifter always takes the top bit
    function automatic logic [`RESULT_BITS-1:0] reg_val(input logic [2:0] rs,
            input adc_ctrl_pkg::ctrl_state_t s);
        reg_val = '0;
        if (rs == `RS_STATUS) begin
            reg_val[`RESULT_BITS-1] = s.rdy_n;
        end else if (rs == `RS_MODE) begin
            reg_val[`RESULT_BITS-1 -: 16] = s.mode;
        end else if (rs == `RS_CONF) begin
            reg_val[`RESULT_BITS-1 -: 16] = s.conf;
        end else if (rs == `RS_DATA) begin
            reg_val = s.data;
        end
    endfunction : reg_val

    // Filter output is two's complement, left-aligned; unipolar clamps negatives to zero
    function automatic logic [`RESULT_BITS-1:0] code(input logic [`RESULT_BITS-1:0] s,
            input logic uni);
        if (!uni) begin
            return {~s[`RESULT_BITS-1], s[`RESULT_BITS-2:0]};
        end else if (s[`RESULT_BITS-1]) begin
            return '0;
        end else begin
            // Bottom bit repeated so the top of the range reads all ones
            return {s[`RESULT_BITS-2:0], s[0]};
        end
    endfunction : code

    // Pin synchronisers survive a reset so edge detection stays clean
    function automatic adc_ctrl_pkg::ctrl_state_t rst_state(
            input adc_ctrl_pkg::ctrl_state_t cur);
        adc_ctrl_pkg::ctrl_state_t r;
        r = '0;
        r.sclk_s = cur.sclk_s;
        r.cs_s = cur.cs_s;
        r.din_s = cur.din_s;
        r.rdy_n = 1'b1;
        r.dout = 1'b1;
        r.oe_n = 1'b1;
        r.wait_cnt = 32'(RST_WAIT_CYC - 1);
        r.mode = `MODE_RST;
        r.conf = `CONF_RST;
        r.cv = adc_ctrl_pkg::CV_RUN;
        r.flt_rst = 1'b1;
        return r;
    endfunction : rst_state

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.sclk_s = {st_q.sclk_s[1:0], sclk_in};
        st_d.cs_s = {st_q.cs_s[0], cs_n_in};
        st_d.din_s = {st_q.din_s[0], din_in};
        st_d.flt_rst = 1'b0;
        rise_ev = st_q.sclk_s[1] && !st_q.sclk_s[2] && !st_q.cs_s[1] && st_q.wait_cnt == 32'h0;
        fall_ev = !st_q.sclk_s[1] && st_q.sclk_s[2] && !st_q.cs_s[1] && st_q.wait_cnt == 32'h0;
        shifting = st_q.ph == adc_ctrl_pkg::PH_RD || (st_q.cread && !st_q.rdy_n);
        single = st_q.mode[`MD_MSB:`MD_LSB] == `MD_SINGLE;
        lim = single ? 32'(`CONV_PERIODS * RATE_CYC - 1) : 32'(RATE_CYC - 1);
        conv_end = 1'b0;
        cmd_done = 1'b0;
        rd_done = 1'b0;
        ones_rst = 1'b0;
        cmd = {st_q.in_sh[6:0], st_q.din_s[1]};
        wd = {st_q.in_sh[`RESULT_BITS-2:0], st_q.din_s[1]};
        if (st_q.wait_cnt != 32'h0) begin
            st_d.wait_cnt = st_q.wait_cnt - 32'h1;
        end
        // Conversion timing
        case (st_q.cv)
            adc_ctrl_pkg::CV_RUN: begin
                st_d.tmr = st_q.tmr + 32'h1;
                if (st_q.tmr == lim) begin
                    conv_end = 1'b1;
                    st_d.tmr = 32'h0;
                    if (single) begin
                        st_d.cv = adc_ctrl_pkg::CV_OFF;
                    end
                end
            end
            adc_ctrl_pkg::CV_WAKE: begin
                st_d.tmr = st_q.tmr + 32'h1;
                if (st_q.tmr == 32'(WAKE_CYC - 1)) begin
                    st_d.cv = adc_ctrl_pkg::CV_RUN;
                    st_d.tmr = 32'h0;
                end
            end
            default: begin
                st_d.tmr = 32'h0;
            end
        endcase
        // Serial input side
        if (rise_ev) begin
            st_d.ones = st_q.din_s[1] ? st_q.ones + 6'h1 : 6'h0;
            ones_rst = st_q.din_s[1] && st_q.ones == 6'(`ONES_RESET_COUNT - 1);
            st_d.in_sh = wd;
            if (shifting) begin
                st_d.out_cnt = st_q.out_cnt + 5'h1;
                if (st_q.out_cnt == st_q.len - 5'h1) begin
                    rd_done = 1'b1;
                    st_d.ph = adc_ctrl_pkg::PH_CMD;
                    st_d.out_cnt = 5'h0;
                    if (st_q.cread || st_q.rs == `RS_DATA) begin
                        st_d.rdy_n = 1'b1;
                    end
                end
            end
            case (st_q.ph)
                adc_ctrl_pkg::PH_CMD: begin
                    st_d.in_cnt = st_q.in_cnt + 5'h1;
                    if (st_q.in_cnt == `CMD_LAST_BIT) begin
                        st_d.in_cnt = 5'h0;
                        cmd_done = !cmd[`CMD_WEN_BIT];
                    end
                end
                adc_ctrl_pkg::PH_WR: begin
                    st_d.in_cnt = st_q.in_cnt + 5'h1;
                    if (st_q.in_cnt == st_q.len - 5'h1) begin
                        st_d.in_cnt = 5'h0;
                        st_d.ph = adc_ctrl_pkg::PH_CMD;
                        if (st_q.rs == `RS_MODE) begin
                            st_d.mode = wd[15:0];
                            st_d.tmr = 32'h0;
                            if (wd[`MD_MSB:`MD_LSB] == `MD_SINGLE) begin
                                st_d.cv = adc_ctrl_pkg::CV_WAKE;
                            end else if (wd[`MD_MSB:`MD_LSB] == `MD_CONT) begin
                                st_d.cv = adc_ctrl_pkg::CV_RUN;
                            end else begin
                                st_d.cv = adc_ctrl_pkg::CV_OFF;
                            end
                        end else if (st_q.rs == `RS_CONF) begin
                            st_d.conf = wd[15:0];
                        end
                    end
                end
                default: begin
                    st_d.in_cnt = 5'h0;
                end
            endcase
        end
        // Command decode; in continuous read only the exit byte counts
        if (cmd_done) begin
            if (st_q.cread) begin
                if (cmd == `CMD_CREAD_OFF && !st_q.rdy_n) begin
                    st_d.cread = 1'b0;
                end
            end else begin
                st_d.rs = cmd[`CMD_RS_MSB:`CMD_RS_LSB];
                st_d.len = reg_len(cmd[`CMD_RS_MSB:`CMD_RS_LSB]);
                if (!cmd[`CMD_RD_BIT]) begin
                    st_d.ph = adc_ctrl_pkg::PH_WR;
                end else if (cmd[`CMD_RS_MSB:`CMD_RS_LSB] == `RS_DATA && cmd[`CMD_CREAD_BIT]) begin
                    st_d.cread = 1'b1;
                    st_d.len = 5'(RES_W);
                end else begin
                    st_d.ph = adc_ctrl_pkg::PH_RD;
                    st_d.out_sh = reg_val(cmd[`CMD_RS_MSB:`CMD_RS_LSB], st_q);
                    st_d.out_cnt = 5'h0;
                end
            end
        end
        if (fall_ev && shifting) begin
            st_d.dout = st_q.out_sh[`RESULT_BITS-1];
            st_d.out_sh = {st_q.out_sh[`RESULT_BITS-2:0], 1'b0};
        end
        // Two-entry result buffer; a full buffer drops the new conversion
        push = conv_end && st_q.cnt != `BUF_DEPTH;
        pop = st_q.cnt != 2'h0 && (st_d.ph != adc_ctrl_pkg::PH_RD || st_d.cread);
        if (push) begin
            st_d.fifo[st_q.wp] = code(sample_in, st_q.conf[`CONF_UNI_BIT]);
            st_d.wp = !st_q.wp;
        end
        if (pop) begin
            st_d.data = st_q.fifo[st_q.rp];
            st_d.rp = !st_q.rp;
            st_d.rdy_n = 1'b0;
            if (st_d.cread) begin
                st_d.out_sh = st_q.fifo[st_q.rp];
                st_d.out_cnt = 5'h0;
            end
        end
        st_d.cnt = st_q.cnt + 2'(push) - 2'(pop);
        st_d.oe_n = st_q.cs_s[1];
        if (st_q.cs_s[1]) begin
            st_d.dout = 1'b1;
            st_d.ph = adc_ctrl_pkg::PH_CMD;
            st_d.in_cnt = 5'h0;
            st_d.out_cnt = 5'h0;
        end else if (pop && st_d.cread && !(fall_ev && shifting)) begin
            // Ready low first; the word's top bit follows on the next fall
            st_d.dout = 1'b0;
        end else if (!(st_d.ph == adc_ctrl_pkg::PH_RD || (st_d.cread && !st_d.rdy_n))) begin
            st_d.dout = st_d.rdy_n;
        end
        if (srst_in || ones_rst) begin
            st_d = rst_state(st_d);
        end
    end

    always_ff @(posedge core_clk_in) begin
        st_q <= st_d;
    end

    assign dout_out = st_q.dout;
    assign dout_oe_n_out = st_q.oe_n;
    assign burnout_en_out = st_q.conf[`CONF_BO_BIT];
    assign conv_active_out = st_q.cv != adc_ctrl_pkg::CV_OFF;
    assign filter_rst_out = st_q.flt_rst;
    assign serial_busy_out = st_q.wait_cnt != 32'h0;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    single_off_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
        conv_end && single && !ones_rst |=> st_q.cv == adc_ctrl_pkg::CV_OFF && !conv_end)
        else $error("single conversion did not shut down");
    wake_hold_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
        st_q.cv == adc_ctrl_pkg::CV_WAKE && st_q.tmr < 32'(WAKE_CYC - 1) && !rise_ev
        |=> st_q.cv == adc_ctrl_pkg::CV_WAKE)
        else $error("oscillator wake cut short");
    conv_restart_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
        conv_end |=> st_q.tmr == 32'h0)
        else $error("conversion timer not restarted");
    ready_low_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
        pop && !ones_rst |=> !st_q.rdy_n)
        else $error("ready flag not cleared on new result");
    read_high_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
        rd_done && (st_q.cread || st_q.rs == `RS_DATA) && !pop && !st_q.cs_s[1]
        |=> st_q.rdy_n && st_q.dout)
        else $error("ready not raised after data read");
    cread_enter_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
        cmd_done && !st_q.cread && cmd == `CMD_CREAD_ON && !ones_rst |=> st_q.cread)
        else $error("continuous read not entered");
    cread_exit_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
        cmd_done && st_q.cread && cmd == `CMD_CREAD_OFF && !st_q.rdy_n |=> !st_q.cread)
        else $error("continuous read not left");
    ones_reset_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
        ones_rst |=> st_q.mode == `MODE_RST && st_q.conf == `CONF_RST && filter_rst_out
        && serial_busy_out && st_q.ph == adc_ctrl_pkg::PH_CMD)
        else $error("serial reset incomplete");
    msb_first_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
        fall_ev && shifting |=> st_q.dout == $past(st_q.out_sh[`RESULT_BITS-1]))
        else $error("output bit order wrong");
    deselect_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
        st_q.cs_s[1] |=> dout_oe_n_out && dout_out)
        else $error("pin driven while deselected");
    bipolar_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
        push && !st_q.conf[`CONF_UNI_BIT] && !ones_rst
        |=> st_q.fifo[$past(st_q.wp)][`RESULT_BITS-1] != $past(sample_in[`RESULT_BITS-1]))
        else $error("offset binary sign wrong");
endmodule : adc_conversion_readout_control
`default_nettype wire

// ### verif/host_model.sv
// Host serial port model that drives the converter's link pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic dout_line_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic din_out
);
    initial begin
        sclk_out = 1'b1;
        cs_n_out = 1'b1;
        din_out = 1'b0;
    end
    // Select edges get margin for the pin synchronisers
    task automatic sel(input logic on);
        #100;
        cs_n_out = ~on;
        #100;
    endtask : sel
    // Clock idles high between transfers and runs freely within one; shift on fall, sample on rise
    task automatic shift(input logic [23:0] tx, input int n, output logic [23:0] rx);
        rx = 24'h000000;
        for (int i = n - 1; i >= 0; i--) begin
            sclk_out = 1'b0;
            din_out = tx[i];
            #62.5;
            sclk_out = 1'b1;
            rx[i] = dout_line_in;
            #62.5;
        end
        din_out = 1'b0;
    endtask : shift
    // Command byte leads every transaction except continuous-read word reads
    task automatic put_byte(input logic [7:0] b);
        logic [23:0] r;
        shift({16'h0000, b}, 8, r);
    endtask : put_byte
    task automatic put_half(input logic [15:0] h);
        logic [23:0] r;
        shift({8'h00, h}, 16, r);
    endtask : put_half
    task automatic get_byte(output logic [7:0] b);
        logic [23:0] r;
        shift(24'h000000, 8, r);
        b = r[7:0];
    endtask : get_byte
    task automatic get_half(output logic [15:0] h);
        logic [23:0] r;
        shift(24'h000000, 16, r);
        h = r[15:0];
    endtask : get_half
    task automatic get_word(output logic [23:0] w);
        shift(24'h000000, 24, w);
    endtask : get_word
endmodule : host_model
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench of the conversion and readout control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ----------------------------------------
    // Set-up
    // ----------------------------------------
    localparam int RATE = 4000;
    localparam int WAKE = 400;
    logic clk = 1'b0;
    logic srst;
    logic [23:0] sample;
    logic dout, dout_oe_n, burnout_en, conv_active, filter_rst, serial_busy;
    logic sclk, cs_n, din, dout_line;
    logic [23:0] frst_cnt = 24'h000000;
    int checks = 0;
    int errors = 0;
    always #2.5 clk = ~clk;
    // Released line floats; the inverse keeps a stale bit from passing
    assign dout_line = dout_oe_n ? ~dout : dout;
    logic frst_prev = 1'b0;
    // Counts reset pulses, not the cycles that a held reset lasts
    always @(posedge clk) begin
        frst_prev <= filter_rst;
        if (filter_rst === 1'b1 && frst_prev !== 1'b1) frst_cnt <= frst_cnt + 24'h000001;
    end
    adc_conversion_readout_control #(.RES_W(24), .WAKE_CYC(WAKE), .RST_WAIT_CYC(20),
        .RATE_CYC(RATE)) adc_conversion_readout_control_i (
        .core_clk_in(clk), .srst_in(srst), .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din),
        .sample_in(sample), .dout_out(dout), .dout_oe_n_out(dout_oe_n),
        .burnout_en_out(burnout_en), .conv_active_out(conv_active),
        .filter_rst_out(filter_rst), .serial_busy_out(serial_busy));
    host_model host_model_i (.dout_line_in(dout_line), .sclk_out(sclk), .cs_n_out(cs_n),
        .din_out(din));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic set_sample(input logic [23:0] v);
        cyc(1);
        sample = v;
    endtask : set_sample
    task automatic wr(input logic [7:0] cmd, input logic [15:0] v);
        host_model_i.sel(1'b1);
        host_model_i.put_byte(cmd);
        host_model_i.put_half(v);
        host_model_i.sel(1'b0);
    endtask : wr
    // Selects the part and waits for the ready-low indication
    task automatic wait_rdy(output int n);
        host_model_i.sel(1'b1);
        n = 0;
        while (dout_line !== 1'b0 && n < 3 * RATE + 500) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_rdy
    // Read starts right after ready so it ends long before the next result
    task automatic read_data(input logic [23:0] exp);
        logic [23:0] w;
        host_model_i.put_byte(8'h58);
        host_model_i.get_word(w);
        check("data word", w, exp);
        check("line after read", 24'(dout_line), 24'h000001);
    endtask : read_data
    task automatic count_lows(input int span, output logic [23:0] lows);
        lows = 24'h000000;
        repeat (span) begin
            @(posedge clk);
            if (dout_line !== 1'b1) lows++;
        end
    endtask : count_lows
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset;
        check("busy", 24'(serial_busy), 24'h000001);
        check("burnout", 24'(burnout_en), 24'h000000);
        check("converting", 24'(conv_active), 24'h000001);
        cyc(30);
        check("busy end", 24'(serial_busy), 24'h000000);
        check("filter resets", frst_cnt, 24'h000001);
    endtask : test_reset
    task automatic test_conv;
        int n;
        logic [7:0] st;
        wait_rdy(n);
        check("first result", 24'(n <= RATE + 100), 24'h000001);
        host_model_i.put_byte(8'h40);
        host_model_i.get_byte(st);
        check("status ready", {16'h0000, st}, 24'h000000);
        read_data(24'h923456);
        host_model_i.put_byte(8'h40);
        host_model_i.get_byte(st);
        check("status after read", {16'h0000, st}, 24'h000080);
        read_data(24'h923456);
        host_model_i.sel(1'b0);
    endtask : test_conv
    task automatic test_coding;
        logic [23:0] smp [4] = '{24'h000000, 24'hff0000, 24'h400000, 24'h800000};
        logic [23:0] exp [4] = '{24'h000000, 24'h000000, 24'h800000, 24'h000000};
        logic uni [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
        int n;
        for (int i = 0; i < 4; i++) begin
            set_sample(smp[i]);
            wr(8'h10, {2'b00, 1'b1, uni[i], 12'h000});
            check("burnout on", 24'(burnout_en), 24'h000001);
            wait_rdy(n);
            read_data(exp[i]);
            host_model_i.sel(1'b0);
        end
    endtask : test_coding
    task automatic test_single;
        int n;
        logic [23:0] lows;
        set_sample(24'h000001);
        wr(8'h08, 16'h2000);
        wait_rdy(n);
        check("wake and two periods", 24'(n >= WAKE + 2 * RATE - 150), 24'h000001);
        check("result not late", 24'(n <= WAKE + 2 * RATE + 50), 24'h000001);
        read_data(24'h800001);
        count_lows(2 * RATE, lows);
        check("no second result", lows, 24'h000000);
        check("shut down", 24'(conv_active), 24'h000000);
        host_model_i.sel(1'b0);
    endtask : test_single
    task automatic test_cread;
        int n;
        logic [23:0] w;
        logic [23:0] lows;
        wr(8'h08, 16'h0000);
        set_sample(24'h0abcde);
        host_model_i.sel(1'b1);
        host_model_i.put_byte(8'h5c);
        wait_rdy(n);
        host_model_i.get_word(w);
        check("stream word", w, 24'h8abcde);
        count_lows(RATE / 2, lows);
        check("read once", lows, 24'h000000);
        set_sample(24'h000111);
        wait_rdy(n);
        set_sample(24'h000222);
        cyc(RATE + 100);
        host_model_i.get_word(w);
        check("unread word replaced", w, 24'h800222);
        set_sample(24'h000333);
        wait_rdy(n);
        host_model_i.put_byte(8'h58);
        host_model_i.sel(1'b0);
        host_model_i.sel(1'b1);
        read_data(24'h800333);
        host_model_i.sel(1'b0);
    endtask : test_cread
    task automatic test_ones;
        logic [15:0] h;
        wr(8'h10, 16'h2000);
        check("burnout set", 24'(burnout_en), 24'h000001);
        host_model_i.sel(1'b1);
        repeat (4) host_model_i.put_byte(8'hff);
        host_model_i.sel(1'b0);
        check("burnout cleared", 24'(burnout_en), 24'h000000);
        check("converting again", 24'(conv_active), 24'h000001);
        cyc(30);
        check("filter reset", frst_cnt, 24'h000002);
        host_model_i.sel(1'b1);
        host_model_i.put_byte(8'h50);
        host_model_i.get_half(h);
        host_model_i.sel(1'b0);
        check("config default", {8'h00, h}, 24'h000000);
    endtask : test_ones
    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    // About one and a half times the expected run length
    initial begin
        #450000;
        errors++;
        end_of_test();
    end
    initial begin
        srst = 1'b1;
        sample = 24'h123456;
        repeat (6) @(posedge clk);
        #1;
        srst = 1'b0;
        cyc(1);
        test_reset();
        test_conv();
        test_coding();
        test_single();
        test_cread();
        test_ones();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
